// ### src/ist_pkg.sv
package ist_pkg;

   // Clock and modulator rates
   localparam int unsigned CLK_HZ     = 10_000_000;
   localparam int unsigned MOD_HZ     = 1_000_000;
   localparam logic [3:0]  MOD_DIV    = 4'(CLK_HZ / MOD_HZ);
   localparam logic [3:0]  DEC_LAST   = 4'hf;          // Ratio 16, count 0..15
   localparam int unsigned SINC_W     = 23;

   // Automatic startup self-test settle time
   localparam int unsigned AUTO_SETTLE_US  = 2000;
   localparam int unsigned AUTO_SETTLE_CYC = (AUTO_SETTLE_US * (CLK_HZ / 1_000_000));

   // Register offsets
   localparam logic [7:0] OFS_CFG5     = 8'h00;
   localparam logic [7:0] OFS_STAT     = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_DATA     = 8'h10;
   localparam logic [7:0] OFS_LIM_LO   = 8'h14;
   localparam logic [7:0] OFS_LIM_HI   = 8'h18;

   // channel_user_config_five field positions
   localparam int unsigned CFG_SEL_LSB   = 0;
   localparam int unsigned CFG_INIT_BIT  = 4;
   localparam int unsigned CFG_RATE_LSB  = 5;
   localparam int unsigned CFG_SHIFT_LSB = 8;
   localparam int unsigned CFG_MULT_LSB  = 16;

   // channel_state_reg bit positions
   localparam int unsigned STAT_FAIL_BIT  = 0;
   localparam int unsigned STAT_AUTO_BIT  = 1;
   localparam int unsigned STAT_PH2E_BIT  = 2;
   localparam int unsigned STAT_INIT_BIT  = 3;

   // Interrupt bits
   localparam int unsigned IRQ_W        = 3;
   localparam int unsigned IRQ_SAMPLE   = 0;
   localparam int unsigned IRQ_AUTODONE = 1;
   localparam int unsigned IRQ_AUTOFAIL = 2;

   // Reset values and automatic-test gain minimums
   localparam logic [SINC_W-1:0] LIM_LO_RST = 23'h000100;
   localparam logic [SINC_W-1:0] LIM_HI_RST = 23'h000c00;
   localparam logic [1:0]        GSHIFT_MIN = 2'h0;
   localparam logic [7:0]        GMULT_MIN  = 8'h00;

   // Override words
   localparam logic [SINC_W-1:0] PAT0_WORD = 23'h000000;
   localparam logic [SINC_W-1:0] PAT1_WORD = 23'h7fffff;
   localparam logic [SINC_W-1:0] PAT2_WORD = 23'h2aaaaa;
   localparam logic [SINC_W-1:0] PAT3_WORD = 23'h555555;
   localparam logic [SINC_W-1:0] ERR_WORD  = 23'h400000;

   typedef enum logic [3:0] {
      ST_OFF    = 4'h0,
      ST_ANA_LO = 4'h1,
      ST_ANA_HI = 4'h2,
      ST_DIG    = 4'h3,
      ST_PAT0   = 4'h4,
      ST_PAT1   = 4'h5,
      ST_PAT2   = 4'h6,
      ST_PAT3   = 4'h7
   } ist_sel_e;

   typedef enum logic [2:0] {
      AS_WAIT   = 3'h0,
      AS_SETTLE = 3'h1,
      AS_MEAS   = 3'h2,
      AS_PASS   = 3'h3,
      AS_FAIL   = 3'h4,
      AS_NONE   = 3'h5
   } ist_auto_e;

   typedef struct packed {
      logic [SINC_W-1:0] data;
      logic              valid;
   } ist_sample_s;

endpackage

// ### src/ist_sinc3.sv
`timescale 1ns/1ps
module ist_sinc3
   import ist_pkg::*;
(
   input  wire logic        clk,      // System clock
   input  wire logic        nrst,     // Synchronous reset, active low
   input  wire logic        en,       // 1 MHz bit strobe
   input  wire logic        bit_in,   // Modulator bit
   input  wire logic [1:0]  rate,     // Output rate select
   output ist_sample_s      smp       // Decimated word and pulse
);

   typedef struct packed {
      logic [SINC_W-1:0] i1, i2, i3, d1, d2, d3;
      logic [3:0]        cnt;
      logic [1:0]        keep;
      ist_sample_s       out;
   } ist_sinc_s;

   ist_sinc_s s_reg, s_next;
   logic [SINC_W-1:0] x, c1, c2, c3;
   logic [1:0]        keep_mask;

   always_comb begin
      s_next    = s_reg;
      s_next.out.valid = 1'b0;
      x         = bit_in ? 23'h000001 : 23'h7fffff;
      c1        = s_reg.i3 - s_reg.d1;
      c2        = c1 - s_reg.d2;
      c3        = c2 - s_reg.d3;
      keep_mask = (rate == 2'h3) ? 2'h3 : ((rate == 2'h2) ? 2'h1 : 2'h0);
      if (en) begin
         s_next.i1  = s_reg.i1 + x;
         s_next.i2  = s_reg.i2 + s_reg.i1;
         s_next.i3  = s_reg.i3 + s_reg.i2;
         s_next.cnt = s_reg.cnt + 4'h1;
         if (s_reg.cnt == DEC_LAST) begin
            s_next.d1   = s_reg.i3;
            s_next.d2   = c1;
            s_next.d3   = c2;
            s_next.keep = s_reg.keep + 2'h1;
            if ((s_reg.keep & keep_mask) == 2'h0) begin
               s_next.out.data  = c3;
               s_next.out.valid = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign smp = s_reg.out;

endmodule // ist_sinc3

// ### src/ist_top.sv
// Operation
// - Self-test is selected only by software writes to a four-bit field; the PSI5 startup test selects the low voltage without one.
// - Two analog deflection voltages per range, chosen by the selection field.
// - Digital self-test may start only while init done is clear.
// - Digital self-test injects a known stream; output settles to fixed value.
// - Fixed-pattern self-test may start only while init done is clear.
// - Fixed-pattern self-test overrides output so every data bit is checkable.
// - In PSI5 mode the startup self-test runs automatically, no host request.
// - During automatic self-test gain shift and multiplier are forced to minimum.
// - Failed startup test ends phase two with error; error words replace data.
// - Failure flag set by the startup test clears only by device reset.
// - Input is the one-bit stream of a second-order sigma-delta modulator.
// - The modulator bitstream is sampled at 1 MHz.
// - Third-order sinc decimator, ratio 16, parallel output words.
// - Decimator turns the serial bit stream into a parallel sample value.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module ist_top
   import ist_pkg::*;
#(
   parameter logic [15:0] SETTLE_CYC = 16'(AUTO_SETTLE_CYC)
) (
   input  wire logic        CLK_SYS,        // 10 MHz system clock
   input  wire logic        NRST,           // Synchronous reset, active low
   input  wire logic        PSEL,           // APB select
   input  wire logic        PENABLE,        // APB enable
   input  wire logic        PWRITE,         // APB direction
   input  wire logic [7:0]  PADDR,          // APB byte address
   input  wire logic [31:0] PWDATA,         // APB write data
   output logic      [31:0] PRDATA,         // APB read data
   output logic             PREADY,         // APB ready
   output logic             PSLVERR,        // APB error, unmapped address
   input  wire logic        MOD_BITSTREAM,  // Modulator bit, asynchronous pin
   input  wire logic        PSI5_STRAP,     // PSI5 mode strap, asynchronous pin
   output logic      [1:0]  ST_VOLT_SEL,    // Analog deflection voltage select
   output logic      [1:0]  GAIN_SHIFT,     // Gain shift to user scaling
   output logic      [7:0]  GAIN_MULT,      // Gain multiplier to user scaling
   output logic      [22:0] SENS_DATA,      // Sample word to the trim stage
   output logic             SENS_VALID,     // One-cycle sample strobe
   output logic             INIT_PHASE2_ERR, // Phase two ended in self-test error
   output logic             IRQ             // Level interrupt
);

   typedef struct packed {
      logic              mod_s1, mod_s2, psi_s1, psi_s2;
      logic [3:0]        div;
      logic              tick;
      logic [1:0]        stim_ph;
      logic [3:0]        sel;
      logic              init_done;
      logic [1:0]        rate;
      logic [1:0]        gshift, gmult_pad;
      logic [7:0]        gmult;
      logic [SINC_W-1:0] lim_lo, lim_hi;
      logic              psi5_mode, strap_taken;
      logic              fail, ph2_err;
      ist_auto_e         auto_st;
      logic [15:0]       auto_cnt;
      logic [IRQ_W-1:0]  irq_stat, irq_mask;
      logic [SINC_W-1:0] data_out;
      logic              data_valid;
      logic              pready, pslverr;
      logic [31:0]       prdata;
      logic              irq;
      logic [1:0]        vsel, gshift_out;
      logic [7:0]        gmult_out;
   } ist_top_s;

   ist_top_s    s_reg, s_next;
   ist_sample_s sinc_smp;
   logic        sinc_bit;
   logic        auto_run;
   logic        acc, wr, rd;
   logic        mapped;
   logic        in_range;
   logic [3:0]  eff_sel;
   logic [3:0]  new_sel;
   logic [IRQ_W-1:0] ev;
   logic [31:0] rdata;

   // Stimulus replaces the modulator only in digital self-test
   assign sinc_bit = (s_reg.sel == ST_DIG) ? (s_reg.stim_ph != 2'h0) : s_reg.mod_s2;

   ist_sinc3 u_sinc (
      .clk    (CLK_SYS),
      .nrst   (NRST),
      .en     (s_reg.tick),
      .bit_in (sinc_bit),
      .rate   (s_reg.rate),
      .smp    (sinc_smp)
   );

   function automatic logic is_init_only(input logic [3:0] code);
      is_init_only = (code >= ST_DIG) && (code <= ST_PAT3);
   endfunction

   always_comb begin
      s_next  = s_reg;
      ev      = '0;
      new_sel = s_reg.sel;

      // Pins cross into the clock domain through two flops
      s_next.mod_s1 = MOD_BITSTREAM;
      s_next.mod_s2 = s_reg.mod_s1;
      s_next.psi_s1 = PSI5_STRAP;
      s_next.psi_s2 = s_reg.psi_s1;

      // 1 MHz bit strobe from the 10 MHz clock
      s_next.tick = 1'b0;
      if (s_reg.div == MOD_DIV - 4'h1) begin
         s_next.div  = 4'h0;
         s_next.tick = 1'b1;
      end else begin
         s_next.div = s_reg.div + 4'h1;
      end
      // Three ones in four: a steady mid-scale positive value
      if (s_reg.tick) begin
         s_next.stim_ph = s_reg.stim_ph + 2'h1;
      end

      // Strap taken at the first strobe, well after the sync flops filled
      if (s_reg.tick && !s_reg.strap_taken) begin
         s_next.strap_taken = 1'b1;
         s_next.psi5_mode   = s_reg.psi_s2;
      end

      // Automatic startup self-test
      auto_run = (s_reg.auto_st == AS_SETTLE) || (s_reg.auto_st == AS_MEAS);
      in_range = ($signed(sinc_smp.data) >= $signed(s_reg.lim_lo)) &&
                 ($signed(sinc_smp.data) <= $signed(s_reg.lim_hi));
      unique case (s_reg.auto_st)
         AS_WAIT: begin
            if (s_reg.strap_taken) begin
               s_next.auto_st  = s_reg.psi5_mode ? AS_SETTLE : AS_NONE;
               s_next.auto_cnt = '0;
            end
         end
         AS_SETTLE: begin
            if (s_reg.auto_cnt >= SETTLE_CYC - 16'h1) begin
               s_next.auto_st = AS_MEAS;
            end else begin
               s_next.auto_cnt = s_reg.auto_cnt + 16'h1;
            end
         end
         AS_MEAS: begin
            if (sinc_smp.valid) begin
               ev[IRQ_AUTODONE] = 1'b1;
               if (!in_range) begin
                  s_next.fail      = 1'b1;
                  s_next.ph2_err   = 1'b1;
                  s_next.auto_st   = AS_FAIL;
                  ev[IRQ_AUTOFAIL] = 1'b1;
               end else begin
                  s_next.auto_st = AS_PASS;
               end
            end
         end
         AS_PASS, AS_FAIL, AS_NONE: begin
            s_next.auto_st = s_reg.auto_st;
         end
         default: begin
            s_next.auto_st = AS_NONE;
         end
      endcase

      // Effective selection; the automatic test borrows the low voltage
      eff_sel = auto_run ? ST_ANA_LO : s_reg.sel;
      unique case (eff_sel)
         ST_ANA_LO: s_next.vsel = 2'h1;
         ST_ANA_HI: s_next.vsel = 2'h2;
         default:   s_next.vsel = 2'h0;
      endcase
      s_next.gshift_out = auto_run ? GSHIFT_MIN : s_reg.gshift;
      s_next.gmult_out  = auto_run ? GMULT_MIN : s_reg.gmult;

      // Output word: error, fixed pattern or decimator value
      s_next.data_valid = sinc_smp.valid;
      if (sinc_smp.valid) begin
         ev[IRQ_SAMPLE] = 1'b1;
         if (s_reg.fail) begin
            s_next.data_out = ERR_WORD;
         end else begin
            unique case (s_reg.sel)
               ST_PAT0: s_next.data_out = PAT0_WORD;
               ST_PAT1: s_next.data_out = PAT1_WORD;
               ST_PAT2: s_next.data_out = PAT2_WORD;
               ST_PAT3: s_next.data_out = PAT3_WORD;
               default: s_next.data_out = sinc_smp.data;
            endcase
         end
      end

      // APB slave, one wait state so read data comes from a flop
      acc    = PSEL && PENABLE;
      wr     = acc && PWRITE && s_reg.pready;
      rd     = acc && !PWRITE && !s_reg.pready;
      mapped = (PADDR == OFS_CFG5) || (PADDR == OFS_STAT) || (PADDR == OFS_IRQ_STAT) ||
               (PADDR == OFS_IRQ_MASK) || (PADDR == OFS_DATA) ||
               (PADDR == OFS_LIM_LO) || (PADDR == OFS_LIM_HI);
      s_next.pready  = acc && !s_reg.pready;
      s_next.pslverr = acc && !s_reg.pready && !mapped;

      rdata = '0;
      unique case (PADDR)
         OFS_CFG5: begin
            rdata[CFG_SEL_LSB +: 4]   = s_reg.sel;
            rdata[CFG_INIT_BIT]       = s_reg.init_done;
            rdata[CFG_RATE_LSB +: 2]  = s_reg.rate;
            rdata[CFG_SHIFT_LSB +: 2] = s_reg.gshift;
            rdata[CFG_MULT_LSB +: 8]  = s_reg.gmult;
         end
         OFS_STAT: begin
            rdata[STAT_FAIL_BIT] = s_reg.fail;
            rdata[STAT_AUTO_BIT] = auto_run;
            rdata[STAT_PH2E_BIT] = s_reg.ph2_err;
            rdata[STAT_INIT_BIT] = s_reg.init_done;
         end
         OFS_IRQ_STAT: rdata[IRQ_W-1:0]  = s_reg.irq_stat;
         OFS_IRQ_MASK: rdata[IRQ_W-1:0]  = s_reg.irq_mask;
         OFS_DATA:     rdata[SINC_W-1:0] = s_reg.data_out;
         OFS_LIM_LO:   rdata[SINC_W-1:0] = s_reg.lim_lo;
         OFS_LIM_HI:   rdata[SINC_W-1:0] = s_reg.lim_hi;
         default:      rdata = '0;
      endcase
      if (rd) begin
         s_next.prdata = rdata;
      end

      // Set wins over a write-one clear in the same cycle
      s_next.irq_stat = s_reg.irq_stat;
      if (wr && (PADDR == OFS_IRQ_STAT)) begin
         s_next.irq_stat = s_reg.irq_stat & ~PWDATA[IRQ_W-1:0];
      end
      s_next.irq_stat = s_next.irq_stat | ev;

      if (wr) begin
         unique case (PADDR)
            OFS_CFG5: begin
               new_sel = PWDATA[CFG_SEL_LSB +: 4];
               // Digital and pattern tests are refused once init is done
               if (!(is_init_only(new_sel) && s_reg.init_done)) begin
                  s_next.sel = new_sel;
               end
               s_next.rate   = PWDATA[CFG_RATE_LSB +: 2];
               s_next.gshift = PWDATA[CFG_SHIFT_LSB +: 2];
               s_next.gmult  = PWDATA[CFG_MULT_LSB +: 8];
               if (PWDATA[CFG_INIT_BIT]) begin
                  s_next.init_done = 1'b1;
               end
            end
            OFS_IRQ_MASK: s_next.irq_mask = PWDATA[IRQ_W-1:0];
            OFS_LIM_LO:   s_next.lim_lo   = PWDATA[SINC_W-1:0];
            OFS_LIM_HI:   s_next.lim_hi   = PWDATA[SINC_W-1:0];
            default:      s_next.irq_mask = s_reg.irq_mask;
         endcase
      end
      // Leaving initialisation ends any digital or pattern test
      if (s_next.init_done && is_init_only(s_next.sel)) begin
         s_next.sel = ST_OFF;
      end

      s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         s_reg         <= '0;
         s_reg.auto_st <= AS_WAIT;
         s_reg.lim_lo  <= LIM_LO_RST;
         s_reg.lim_hi  <= LIM_HI_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA          = s_reg.prdata;
   assign PREADY          = s_reg.pready;
   assign PSLVERR         = s_reg.pslverr;
   assign ST_VOLT_SEL     = s_reg.vsel;
   assign GAIN_SHIFT      = s_reg.gshift_out;
   assign GAIN_MULT       = s_reg.gmult_out;
   assign SENS_DATA       = s_reg.data_out;
   assign SENS_VALID      = s_reg.data_valid;
   assign INIT_PHASE2_ERR = s_reg.ph2_err;
   assign IRQ             = s_reg.irq;

endmodule // ist_top

// ### sim/ist_chk.sv
`timescale 1ns/1ps
module ist_chk
   import ist_pkg::*;
#(
   parameter logic [15:0] SETTLE_CYC = 16'(AUTO_SETTLE_CYC)
) (
   input wire logic        CLK_SYS,         // System clock
   input wire logic        NRST,            // Sync reset, active low
   input wire logic        PSEL,            // APB select
   input wire logic        PENABLE,         // APB enable
   input wire logic        PWRITE,          // APB direction
   input wire logic [7:0]  PADDR,           // APB address
   input wire logic [31:0] PRDATA,          // APB read data
   input wire logic        PREADY,          // APB ready
   input wire logic        PSLVERR,         // APB error
   input wire logic [1:0]  ST_VOLT_SEL,     // Deflection voltage select
   input wire logic [22:0] SENS_DATA,       // Sample word
   input wire logic        SENS_VALID,      // Sample strobe
   input wire logic        INIT_PHASE2_ERR, // Phase two error
   input wire logic        IRQ              // Interrupt
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   logic [15:0] gap_reg;
   logic [31:0] up_reg;
   logic        seen_reg;
   logic        errv_reg;
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         gap_reg  <= 16'h0000;
         up_reg   <= 32'h00000000;
         seen_reg <= 1'b0;
         errv_reg <= 1'b0;
      end else begin
         gap_reg  <= SENS_VALID ? 16'h0000 : gap_reg + 16'h0001;
         up_reg   <= up_reg + 32'h00000001;
         seen_reg <= seen_reg | SENS_VALID;
         errv_reg <= errv_reg | (SENS_VALID & INIT_PHASE2_ERR);
      end
   end
   sequence s_setup;
      PSEL && !PENABLE ##1 PSEL && PENABLE;
   endsequence
   chk_apb_wait: assert property (s_setup |=> PREADY) else $error("ready late");
   chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
   chk_err_decode: assert property (PREADY |->
      PSLVERR == ((PADDR > OFS_LIM_HI) || (PADDR[1:0] != 2'h0)))
      else $error("bad decode");
   chk_err_rdzero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("error read not zero");
   chk_valid_pulse: assert property (SENS_VALID |=> !SENS_VALID) else $error("wide strobe");
   chk_rate_gap: assert property (SENS_VALID && seen_reg |-> gap_reg >= 16'h009f)
      else $error("samples too close");
   chk_data_hold: assert property (!SENS_VALID && !$past(SENS_VALID) |-> $stable(SENS_DATA))
      else $error("data moved");
   chk_fail_sticky: assert property (INIT_PHASE2_ERR |=> INIT_PHASE2_ERR)
      else $error("error flag dropped");
   chk_err_words: assert property (SENS_VALID && errv_reg |=> SENS_DATA == ERR_WORD)
      else $error("data after failure");
   chk_volt_code: assert property (ST_VOLT_SEL != 2'h3) else $error("bad volt code");
   chk_err_early: assert property ($rose(INIT_PHASE2_ERR) |-> up_reg > 32'(SETTLE_CYC))
      else $error("failure before settle");
   chk_reset_outs: assert property (disable iff (1'b0)
      !NRST |=> !SENS_VALID && !INIT_PHASE2_ERR && !IRQ && !PREADY) else $error("reset outs");
endmodule // ist_chk

bind ist_top ist_chk #(.SETTLE_CYC(SETTLE_CYC)) ist_chk_inst (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .ST_VOLT_SEL(ST_VOLT_SEL), .SENS_DATA(SENS_DATA), .SENS_VALID(SENS_VALID),
   .INIT_PHASE2_ERR(INIT_PHASE2_ERR), .IRQ(IRQ));

// ### sim/ist_mod_model.sv
`timescale 1ns/1ps
module ist_mod_model (
   input  wire logic       clk,     // System clock
   input  wire logic       nrst,    // Sync reset, active low
   input  wire logic [1:0] mode,    // 0 all low, 1 all high, 2 five of eight
   output logic            bit_out  // One-bit modulator stream
);
   // Period eight divides the ratio, so the decimated value is exact
   localparam logic [7:0] FIVE_OF_EIGHT = 8'hb5;
   logic [3:0] div_reg;
   logic [2:0] pos_reg;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_reg <= 4'h0;
         pos_reg <= 3'h0;
         bit_out <= 1'b0;
      end else if (div_reg == 4'h9) begin
         div_reg <= 4'h0;
         pos_reg <= pos_reg + 3'h1;
         bit_out <= (mode == 2'h2) ? FIVE_OF_EIGHT[pos_reg] : mode[0];
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end
endmodule // ist_mod_model

// ### sim/inertial_dsp_selftest_path_tb.sv
`timescale 1ns/1ps
module inertial_dsp_selftest_path_tb;
   import ist_pkg::*;
   localparam int SETTLE = 600;
   logic        clk, nrst, psel, penable, pwrite, strap, rerr, mod_bit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdata, prdata;
   logic [1:0]  mode, volt, gshift;
   logic [7:0]  gmult;
   logic [22:0] sdata;
   logic        pready, pslverr, svalid, p2err, irq;
   int          fails, n_tests, n;

   ist_top #(.SETTLE_CYC(16'(SETTLE))) ist_top_inst (
      .CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MOD_BITSTREAM(mod_bit), .PSI5_STRAP(strap), .ST_VOLT_SEL(volt), .GAIN_SHIFT(gshift),
      .GAIN_MULT(gmult), .SENS_DATA(sdata), .SENS_VALID(svalid), .INIT_PHASE2_ERR(p2err),
      .IRQ(irq));
   ist_mod_model ist_mod_model_inst (.clk(clk), .nrst(nrst), .mode(mode), .bit_out(mod_bit));

   initial clk = 1'b0;
   always #50 clk = ~clk;

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask
   // No cycle count is assumed for ready; only the watchdog ends a stuck wait
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(rdata & m, e);
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] sel, input logic ini,
                                       input logic [1:0] rate);
      return {8'h00, 8'h5a, 6'h00, 2'h2, 1'b0, rate, ini, sel};
   endfunction
   task automatic wv(input int cnt);
      repeat (cnt) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (svalid !== 1'b1);
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic rst(input logic s);
      @(posedge clk);
      nrst  <= 1'b0;
      strap <= s;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
   endtask

   task automatic t_regs;
      rd_chk(OFS_STAT, 32'hf, 32'h0);
      rd_chk(OFS_LIM_LO, 32'h7fffff, 32'(LIM_LO_RST));
      rd_chk(OFS_LIM_HI, 32'h7fffff, 32'(LIM_HI_RST));
      xfer(OFS_STAT, 1'b1, 32'hf);
      rd_chk(OFS_STAT, 32'hf, 32'h0);
      xfer(8'h20, 1'b0, 32'h0);
      chk(rerr, 1'b1);
      chk(rdata, 32'h0);
   endtask
   task automatic t_sel;
      logic [1:0] ev [3];
      ev = '{2'h0, 2'h1, 2'h2};
      for (int s = 0; s < 3; s++) begin
         xfer(OFS_CFG5, 1'b1, cfg(4'(s), 1'b0, 2'h0));
         repeat (2) @(posedge clk);
         chk({gshift, gmult, volt}, {2'h2, 8'h5a, ev[s]});
      end
   endtask
   task automatic t_rates;
      int per [4];
      per = '{160, 160, 320, 640};
      for (int r = 3; r >= 0; r--) begin
         xfer(OFS_CFG5, 1'b1, cfg(4'h0, 1'b0, 2'(r)));
         wv(2);
         wv(1);
         chk(n + 2, per[r]);
      end
      wv(3);
      chk(sdata, 32'h001000);
      mode <= 2'h0;
      wv(4);
      chk(sdata, 32'h7ff000);
      mode <= 2'h1;
   endtask
   task automatic t_dig;
      xfer(OFS_CFG5, 1'b1, cfg(4'h3, 1'b0, 2'h0));
      wv(4);
      chk(sdata, 32'h000800);
   endtask
   task automatic t_pat;
      logic [22:0] pw [4];
      pw = '{PAT0_WORD, PAT1_WORD, PAT2_WORD, PAT3_WORD};
      for (int k = 0; k < 4; k++) begin
         xfer(OFS_CFG5, 1'b1, cfg(4'(4 + k), 1'b0, 2'h0));
         wv(2);
         chk(sdata, pw[k]);
         rd_chk(OFS_DATA, 32'h7fffff, 32'(pw[k]));
      end
   endtask
   task automatic t_init;
      xfer(OFS_CFG5, 1'b1, cfg(4'h3, 1'b1, 2'h0));
      rd_chk(OFS_CFG5, 32'h1f, 32'h10);
      wv(4);
      chk(sdata, 32'h001000);
      xfer(OFS_CFG5, 1'b1, cfg(4'h5, 1'b0, 2'h0));
      wv(2);
      chk(sdata, 32'h001000);
      xfer(OFS_CFG5, 1'b1, cfg(4'h2, 1'b0, 2'h0));
      repeat (2) @(posedge clk);
      chk(volt, 2'h2);
      rd_chk(OFS_STAT, 32'hf, 32'h8);
   endtask
   task automatic t_irq;
      xfer(OFS_IRQ_MASK, 1'b1, 32'h1);
      wv(1);
      chk(irq, 1'b1);
      xfer(OFS_IRQ_STAT, 1'b1, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      xfer(OFS_IRQ_MASK, 1'b1, 32'h0);
      wv(1);
      chk(irq, 1'b0);
      rd_chk(OFS_IRQ_STAT, 32'h7, 32'h1);
   endtask
   // Stored deflection 0x400 with a quarter accuracy gives limits 0x300 and 0x500
   task automatic t_auto(input logic [1:0] md, input logic bad);
      mode <= md;
      rst(1'b1);
      xfer(OFS_LIM_LO, 1'b1, 32'h400 * 3 / 4);
      xfer(OFS_LIM_HI, 1'b1, (32'h400 * 5 + 3) / 4);
      xfer(OFS_CFG5, 1'b1, cfg(4'h0, 1'b0, 2'h0));
      xfer(OFS_IRQ_MASK, 1'b1, 32'h6);
      rd_chk(OFS_STAT, 32'h2, 32'h2);
      chk({gshift, gmult, volt}, {2'h0, 8'h00, 2'h1});
      n = 0;
      while (irq !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      rd_chk(OFS_IRQ_STAT, 32'h6, bad ? 32'h6 : 32'h2);
      rd_chk(OFS_STAT, 32'h7, bad ? 32'h5 : 32'h0);
      chk(p2err, bad);
      chk({gshift, gmult, volt}, {2'h2, 8'h5a, 2'h0});
      wv(2);
      if (bad) chk(sdata, 32'(ERR_WORD));
      else chk(sdata, 32'h000400);
      xfer(OFS_STAT, 1'b1, 32'h0);
      xfer(OFS_CFG5, 1'b1, 32'h0);
      chk(p2err, bad);
   endtask

   initial begin
      fails   = 0;
      n_tests = 0;
      nrst    = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      strap   = 1'b0;
      mode    = 2'h1;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_sel;
      t_rates;
      t_dig;
      t_pat;
      t_init;
      t_irq;
      t_auto(2'h2, 1'b0);
      t_auto(2'h1, 1'b1);
      rst(1'b0);
      repeat (2) @(posedge clk);
      chk(p2err, 1'b0);
      finish_test;
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      finish_test;
   end
endmodule // inertial_dsp_selftest_path_tb
